// [hw/input_dispatch.sv]
// Digital input terminal dispatcher with Avalon-MM register slave
`timescale 1ns/100ps
module input_dispatch
  import dispatch_pkg::*;
#(
  parameter int MIN_PULSE = dispatch_pkg::MIN_PULSE_CYC, // 3 ms in cycles
  parameter int MS_CYC    = dispatch_pkg::CYC_PER_MS     // 1 ms in cycles
) (
  input  wire logic                    I_CLK,            // 20 MHz clock
  input  wire logic                    I_RESET_N,        // Async reset
  input  wire logic [dispatch_pkg::NTERM-1:0] I_TERM,    // Terminal pins
  input  wire logic                    I_TRIP_LOCKED,    // Alarm not resettable
  input  wire logic                    I_OFF_KEY,        // Off/stop key pulse
  input  wire logic [dispatch_pkg::VAL_W-1:0] I_REF_NOW,  // Present reference
  input  wire logic [dispatch_pkg::VAL_W-1:0] I_FREQ_NOW, // Present frequency
  input  wire logic [7:0]              I_AVS_ADDRESS,    // Byte address
  input  wire logic                    I_AVS_READ,       // Read request
  input  wire logic                    I_AVS_WRITE,      // Write request
  input  wire logic [31:0]             I_AVS_WRITEDATA,  // Write data
  input  wire logic [3:0]              I_AVS_BYTEENABLE, // Byte lanes
  output logic      [31:0]             O_AVS_READDATA,   // Read data
  output logic                         O_AVS_WAITREQUEST,// Stall
  output dispatch_pkg::cmd_s           O_CMD,            // Drive commands
  output logic                         O_ALARM_RESET,    // Reset pulse
  output logic                         O_IRQ             // Level interrupt
);
  import dispatch_pkg::*;

  localparam int MSW = $clog2(MS_CYC + 1);
  // Interlock pin idles high; a low reset value would latch a false fault
  localparam logic [NTERM-1:0] LVL_IDLE = NTERM'(1) << INTERLOCK_TERM;

  if (MIN_PULSE < 1 || MS_CYC < 1) begin
    $error("input_dispatch: bad timing");
  end

  // Terminal position to function, per terminal table
  function automatic func_e func_of(input int t, input logic [SEL_W-1:0] c);
    func_e f;
    f = FN_NONE;
    if (t == 2) begin
      if (c == 5'h01) f = FN_START;
    end else if (t == 3) begin
      case (c)
        5'h01: f = FN_REVERSE;
        5'h02: f = FN_REV_START;
        5'h03: f = FN_DC_HOLD;
        default: f = FN_NONE;
      endcase
    end else if (t == INTERLOCK_TERM) begin
      case (c)
        5'h00: f = FN_COAST_LOW;
        5'h01: f = FN_CLR_COAST;
        5'h02: f = FN_DC_HOLD;
        default: f = FN_INTERLOCK;
      endcase
    end else if (t == 5) begin
      case (c)
        5'h01: f = FN_RESET;
        5'h02: f = FN_FREEZE_REF;
        5'h03: f = FN_FREEZE_OUT;
        5'h04: f = FN_SETUP_LSB;
        5'h05: f = FN_SETUP_MSB;
        5'h06: f = FN_PRESET_ON;
        5'h07: f = FN_PRESET_LSB;
        5'h08: f = FN_PRESET_MSB;
        5'h09: f = FN_SPEED_DN;
        5'h0a: f = FN_SPEED_UP;
        default: f = FN_NONE;
      endcase
    end else begin
      // Terminals 0, 1, 6, 7 share codes 1..3; codes 4, 6 alternate lsb/msb and code 7 alternates up/down
      case (c)
        5'h01: f = FN_RESET;
        5'h02: f = FN_FREEZE_REF;
        5'h03: f = FN_FREEZE_OUT;
        5'h04: f = (t == 1 || t == 7) ? FN_SETUP_MSB : FN_SETUP_LSB;
        5'h05: f = FN_PRESET_ON;
        5'h06: f = (t == 1 || t == 7) ? FN_PRESET_MSB : FN_PRESET_LSB;
        5'h07: f = (t == 1 || t == 7) ? FN_SPEED_DN : FN_SPEED_UP;
        default: f = FN_NONE;
      endcase
    end
    return f;
  endfunction

  // True if any terminal mapped to f sits at level lv
  function automatic logic hit(input logic [NTERM*5-1:0] fv,
                               input logic [NTERM-1:0] lvl,
                               input func_e f, input logic lv);
    logic r;
    r = 1'b0;
    for (int t = 0; t < NTERM; t++) begin
      if (fv[t*5 +: 5] == f && lvl[t] == lv) r = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [VAL_W-1:0] stepped(input logic [VAL_W-1:0] v,
                                               input logic up,
                                               input logic dn);
    logic [VAL_W-1:0] r;
    r = v;
    if (up && !dn && v <= {VAL_W{1'b1}} - STEP_SIZE) r = v + STEP_SIZE;
    if (dn && !up && v >= STEP_SIZE) r = v - STEP_SIZE;
    return r;
  endfunction

  // Registers
  logic [NTERM*SEL_W-1:0] sel_q;
  logic                   closed_loop_q;
  logic [31:0]            brake_q;
  logic [IRQ_W-1:0]       istat_q;
  logic [IRQ_W-1:0]       imask_q;
  logic [VAL_W-1:0]       fref_q;
  logic [VAL_W-1:0]       ffrq_q;
  logic                   ack_q;
  logic [31:0]            rdata_q;

  // Function state
  logic [NTERM-1:0] lvl;
  logic             reset_prev_q;
  logic             clrc_prev_q;
  logic             hold_prev_q;
  logic             fref_prev_q;
  logic             ffrq_prev_q;
  logic             run_q;
  logic             ext_fault_q;
  logic [MSW-1:0]   ms_cnt_q;
  logic [15:0]      brake_left_q;
  logic             step_up;
  logic             step_dn;

  level_sync #(.W(NTERM), .RST_VAL(LVL_IDLE)) u_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RESET_N),
    .i_async (I_TERM),
    .o_sync  (lvl)
  );

  // Function of each terminal
  logic [NTERM*5-1:0] fv;
  always_comb begin
    fv = '0;
    for (int t = 0; t < NTERM; t++) begin
      fv[t*5 +: 5] = func_of(t, sel_q[t*SEL_W +: SEL_W]);
    end
  end

  wire reset_hi   = hit(fv, lvl, FN_RESET, 1'b1);
  wire clrc_hi    = hit(fv, lvl, FN_CLR_COAST, 1'b1);
  wire clrc_lo    = hit(fv, lvl, FN_CLR_COAST, 1'b0);
  wire coast_lo   = hit(fv, lvl, FN_COAST_LOW, 1'b0);
  wire lock_lo    = hit(fv, lvl, FN_INTERLOCK, 1'b0);
  wire hold_lo    = hit(fv, lvl, FN_DC_HOLD, 1'b0);
  wire start_hi   = hit(fv, lvl, FN_START, 1'b1);
  wire rev_hi     = hit(fv, lvl, FN_REVERSE, 1'b1);
  wire rstart_hi  = hit(fv, lvl, FN_REV_START, 1'b1);
  wire frz_ref    = hit(fv, lvl, FN_FREEZE_REF, 1'b1);
  wire frz_out    = hit(fv, lvl, FN_FREEZE_OUT, 1'b1);
  wire up_hi      = hit(fv, lvl, FN_SPEED_UP, 1'b1);
  wire dn_hi      = hit(fv, lvl, FN_SPEED_DN, 1'b1);

  // Reset events: rising edge, or falling edge of clear-and-coast
  wire reset_rise = reset_hi && !reset_prev_q;
  wire clrc_fall  = clrc_lo && clrc_prev_q;
  wire reset_evt  = (reset_rise || clrc_fall) && !I_TRIP_LOCKED;
  wire coast      = coast_lo || clrc_lo || lock_lo;

  // DC brake only with nonzero current and time
  wire brake_en   = brake_q[BRAKE_CUR_LSB +: 16] != 16'h0000 &&
                    brake_q[BRAKE_TIME_LSB +: 16] != 16'h0000;
  wire hold_enter = hold_lo && !hold_prev_q;
  wire dc_brake   = hold_lo && brake_en && brake_left_q != 16'h0000;
  wire ms_tick    = ms_cnt_q == MSW'(MS_CYC - 1);

  // Reversing functions are refused in closed loop
  wire open_loop  = !closed_loop_q;
  wire rstart_ok  = rstart_hi && open_loop;
  wire start_clash = start_hi && rstart_hi;
  // Frozen output holds run against the start terminal
  wire run_d      = start_hi || rstart_ok ||
                    (frz_out && run_q && !hold_lo);
  wire freeze_any = frz_ref || frz_out;

  // Speed pulses only matter while something is frozen
  pulse_qualify #(.MIN_CYC(MIN_PULSE)) u_up (
    .i_clk   (I_CLK),
    .i_rst_n (I_RESET_N),
    .i_level (up_hi && freeze_any),
    .o_step  (step_up)
  );
  pulse_qualify #(.MIN_CYC(MIN_PULSE)) u_dn (
    .i_clk   (I_CLK),
    .i_rst_n (I_RESET_N),
    .i_level (dn_hi && freeze_any),
    .o_step  (step_dn)
  );

  // Bus decode: one wait state, write lands when waitrequest is low
  wire        req    = I_AVS_READ || I_AVS_WRITE;
  wire        wr_go  = I_AVS_WRITE && ack_q;
  wire [7:0]  addr   = {I_AVS_ADDRESS[7:2], 2'b00};
  wire        sel_hit = addr < OFS_CTRL;
  wire [2:0]  sel_idx = addr[4:2];
  wire [31:0] wmask  = merge(32'h0, 32'hffffffff, I_AVS_BYTEENABLE);
  wire [SEL_W-1:0] sel_old = sel_q[sel_idx*SEL_W +: SEL_W];
  wire [SEL_W-1:0] sel_new = SEL_W'(merge({27'h0, sel_old}, I_AVS_WRITEDATA,
                                          I_AVS_BYTEENABLE));
  // Interlock terminal keeps its code if a foreign one is written
  wire sel_legal = sel_idx != 3'(INTERLOCK_TERM) ||
                   sel_new <= CODE_INTERLOCK_MAX;
  wire [IRQ_W-1:0] w1c = (wr_go && addr == OFS_ISTAT) ?
                         IRQ_W'(I_AVS_WRITEDATA & wmask) : '0;
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_EXT_FAULT]   = lock_lo && !ext_fault_q;
  assign ev[IRQ_ALARM_RESET] = reset_evt;
  assign ev[IRQ_START_CLASH] = start_clash;
  assign ev[IRQ_STEP]        = step_up || step_dn;

  cmd_s cmd;
  always_comb begin
    cmd            = '0;
    cmd.run        = run_q;
    cmd.reverse    = open_loop && (rev_hi || rstart_hi);
    cmd.coast      = coast;
    cmd.dc_brake   = dc_brake;
    cmd.ext_fault  = ext_fault_q;
    cmd.freeze_ref = frz_ref;
    cmd.freeze_out = frz_out;
    cmd.preset_on  = hit(fv, lvl, FN_PRESET_ON, 1'b1);
    cmd.preset_sel = {hit(fv, lvl, FN_PRESET_MSB, 1'b1),
                      hit(fv, lvl, FN_PRESET_LSB, 1'b1)};
    cmd.setup_sel  = {hit(fv, lvl, FN_SETUP_MSB, 1'b1),
                      hit(fv, lvl, FN_SETUP_LSB, 1'b1)};
  end

  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    if (sel_hit) begin
      rmux = {27'h0, sel_old};
    end else begin
      case (addr)
        OFS_CTRL:  rmux = {31'h0, closed_loop_q};
        OFS_BRAKE: rmux = brake_q;
        OFS_STATE: rmux = {20'h0, cmd};
        OFS_ISTAT: rmux = {28'h0, istat_q};
        OFS_IMASK: rmux = {28'h0, imask_q};
        OFS_FREF:  rmux = {16'h0, fref_q};
        OFS_FFRQ:  rmux = {16'h0, ffrq_q};
        OFS_LEVEL: rmux = {24'h0, lvl};
        default:   rmux = 32'h0;
      endcase
    end
  end

  assign O_AVS_WAITREQUEST = req && !ack_q;
  assign O_AVS_READDATA    = rdata_q;

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= req && !ack_q;
      rdata_q <= (I_AVS_READ && !ack_q) ? rmux : rdata_q;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sel_q         <= SEL_RST;
      closed_loop_q <= 1'b0;
      brake_q       <= 32'h0;
      imask_q       <= '0;
    end else if (wr_go) begin
      if (sel_hit && sel_legal) sel_q[sel_idx*SEL_W +: SEL_W] <= sel_new;
      if (addr == OFS_CTRL) closed_loop_q <= I_AVS_WRITEDATA[CTRL_CLOSED_LOOP];
      if (addr == OFS_BRAKE) brake_q <= merge(brake_q, I_AVS_WRITEDATA,
                                              I_AVS_BYTEENABLE);
      if (addr == OFS_IMASK) imask_q <= IRQ_W'(I_AVS_WRITEDATA);
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      istat_q <= '0;
      O_IRQ   <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~w1c) | ev;
      O_IRQ   <= |(((istat_q & ~w1c) | ev) & imask_q);
    end
  end

  // Edge history, run state, fault latch
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      reset_prev_q  <= 1'b0;
      clrc_prev_q   <= 1'b0;
      hold_prev_q   <= 1'b0;
      fref_prev_q   <= 1'b0;
      ffrq_prev_q   <= 1'b0;
      run_q         <= 1'b0;
      ext_fault_q   <= 1'b0;
      O_ALARM_RESET <= 1'b0;
      O_CMD         <= '0;
    end else begin
      reset_prev_q  <= reset_hi;
      clrc_prev_q   <= clrc_hi;
      hold_prev_q   <= hold_lo;
      fref_prev_q   <= frz_ref;
      ffrq_prev_q   <= frz_out;
      run_q         <= run_d;
      O_ALARM_RESET <= reset_evt;
      O_CMD         <= cmd;
      // Fault stays while interlock is low; set wins over clear
      if (lock_lo) begin
        ext_fault_q <= 1'b1;
      end else if (reset_evt || I_OFF_KEY) begin
        ext_fault_q <= 1'b0;
      end
    end
  end

  // Brake timer in milliseconds
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ms_cnt_q     <= '0;
      brake_left_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      if (hold_enter) begin
        brake_left_q <= brake_q[BRAKE_TIME_LSB +: 16];
      end else if (ms_tick && brake_left_q != 16'h0000) begin
        brake_left_q <= brake_left_q - 16'h0001;
      end
    end
  end

  // Frozen values are never cleared by stop; software saves them
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fref_q <= 16'h0000;
      ffrq_q <= 16'h0000;
    end else begin
      if (frz_ref && !fref_prev_q) begin
        fref_q <= I_REF_NOW;
      end else if (frz_ref) begin
        fref_q <= stepped(fref_q, step_up, step_dn);
      end else if (wr_go && addr == OFS_FREF) begin
        fref_q <= VAL_W'(merge({16'h0, fref_q}, I_AVS_WRITEDATA,
                               I_AVS_BYTEENABLE));
      end
      if (frz_out && !ffrq_prev_q) begin
        ffrq_q <= I_FREQ_NOW;
      end else if (frz_out) begin
        ffrq_q <= stepped(ffrq_q, step_up, step_dn);
      end else if (wr_go && addr == OFS_FFRQ) begin
        ffrq_q <= VAL_W'(merge({16'h0, ffrq_q}, I_AVS_WRITEDATA,
                               I_AVS_BYTEENABLE));
      end
    end
  end
endmodule

// [hw/dispatch_pkg.sv]
// Shared constants, types and register map of the digital input dispatcher
package dispatch_pkg;
  localparam int NTERM  = 8;
  localparam int SEL_W  = 5;
  localparam int VAL_W  = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_SEL0   = 8'h00; // selectors at 0x00..0x1c
  localparam logic [7:0] OFS_CTRL   = 8'h20;
  localparam logic [7:0] OFS_BRAKE  = 8'h24;
  localparam logic [7:0] OFS_STATE  = 8'h28;
  localparam logic [7:0] OFS_ISTAT  = 8'h2c;
  localparam logic [7:0] OFS_IMASK  = 8'h30;
  localparam logic [7:0] OFS_FREF   = 8'h34;
  localparam logic [7:0] OFS_FFRQ   = 8'h38;
  localparam logic [7:0] OFS_LEVEL  = 8'h3c;

  // Field positions
  localparam int CTRL_CLOSED_LOOP = 0;
  localparam int BRAKE_CUR_LSB    = 0;
  localparam int BRAKE_TIME_LSB   = 16;
  localparam int IRQ_W            = 4;
  localparam int IRQ_EXT_FAULT    = 0;
  localparam int IRQ_ALARM_RESET  = 1;
  localparam int IRQ_START_CLASH  = 2;
  localparam int IRQ_STEP         = 3;

  // Selector reset values, terminal 7 down to terminal 0
  localparam logic [NTERM*SEL_W-1:0] SEL_RST =
    {5'h00, 5'h00, 5'h0c, 5'h03, 5'h01, 5'h01, 5'h02, 5'h01};
  localparam logic [SEL_W-1:0] CODE_INTERLOCK_MAX = 5'h03;
  localparam int INTERLOCK_TERM = 4;
  localparam logic [VAL_W-1:0] STEP_SIZE = 16'h0001; // 0.1 % or 0.1 Hz

  // Timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int PULSE_MIN_MS  = 3;
  localparam int CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int MIN_PULSE_CYC = PULSE_MIN_MS * CYC_PER_MS;

  typedef enum logic [4:0] {
    FN_NONE       = 5'h00,
    FN_RESET      = 5'h01,
    FN_COAST_LOW  = 5'h02,
    FN_CLR_COAST  = 5'h03,
    FN_START      = 5'h04,
    FN_REVERSE    = 5'h05,
    FN_REV_START  = 5'h06,
    FN_DC_HOLD    = 5'h07,
    FN_INTERLOCK  = 5'h08,
    FN_FREEZE_REF = 5'h09,
    FN_FREEZE_OUT = 5'h0a,
    FN_SETUP_LSB  = 5'h0b,
    FN_SETUP_MSB  = 5'h0c,
    FN_PRESET_ON  = 5'h0d,
    FN_PRESET_LSB = 5'h0e,
    FN_PRESET_MSB = 5'h0f,
    FN_SPEED_DN   = 5'h10,
    FN_SPEED_UP   = 5'h11
  } func_e;

  typedef struct packed {
    logic       run;
    logic       reverse;
    logic       coast;
    logic       dc_brake;
    logic       ext_fault;
    logic       freeze_ref;
    logic       freeze_out;
    logic       preset_on;
    logic [1:0] preset_sel;
    logic [1:0] setup_sel;
  } cmd_s;
endpackage

// [hw/level_sync.sv]
// Two-stage synchroniser for asynchronous terminal levels
`timescale 1ns/100ps
module level_sync #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,     // Control clock
  input  wire logic         i_rst_n,   // Async reset, active low
  input  wire logic [W-1:0] i_async,   // Raw terminal levels
  output logic      [W-1:0] o_sync     // Synchronised levels
);
  logic [W-1:0] meta_q;

  if (W < 1) begin
    $error("level_sync: W must be at least 1");
  end

  // Reset to the idle level so no false edge or level follows reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// [hw/pulse_qualify.sv]
// Emits one step per input pulse that met minimum high and low widths
`timescale 1ns/100ps
module pulse_qualify #(
  parameter int MIN_CYC = 60000
) (
  input  wire logic i_clk,    // Control clock
  input  wire logic i_rst_n,  // Async reset, active low
  input  wire logic i_level,  // Synchronised speed level
  output logic      o_step    // One-cycle step pulse
);
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(MIN_CYC);

  logic          lvl_q;
  logic [CW-1:0] cnt_q;
  logic          low_ok_q;
  wire           change = i_level != lvl_q;
  wire           wide   = cnt_q >= LIMIT;

  if (MIN_CYC < 1) begin
    $error("pulse_qualify: MIN_CYC must be at least 1");
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl_q    <= 1'b0;
      cnt_q    <= '0;
      low_ok_q <= 1'b1;
      o_step   <= 1'b0;
    end else begin
      lvl_q  <= i_level;
      // Count the edge of the change itself, so a level of N cycles reads N
      cnt_q  <= change ? CW'(1) : (wide ? cnt_q : cnt_q + 1'b1);
      o_step <= change && lvl_q && wide && low_ok_q;
      if (change && !lvl_q) begin
        low_ok_q <= wide;
      end
    end
  end
endmodule

// [verif/dispatch_assertions.sv]
// Port-level assertion checker for the input dispatcher
`timescale 1ns/100ps
module dispatch_chk
  import dispatch_pkg::*;
(
  input wire logic               I_CLK,             // Clock
  input wire logic               I_RESET_N,         // Reset
  input wire logic [NTERM-1:0]   I_TERM,            // Terminals
  input wire logic               I_TRIP_LOCKED,     // Trip lock
  input wire logic               I_AVS_READ,        // Read
  input wire logic               I_AVS_WRITE,       // Write
  input wire logic               O_AVS_WAITREQUEST, // Stall
  input wire dispatch_pkg::cmd_s O_CMD,             // Commands
  input wire logic               O_ALARM_RESET      // Reset pulse
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  chk_wait_one:
    assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("waitrequest longer than one cycle");
  chk_wait_idle:
    assert property (!(I_AVS_READ || I_AVS_WRITE) |-> !O_AVS_WAITREQUEST)
    else $error("waitrequest without request");
  chk_pulse_once:
    assert property (O_ALARM_RESET |=> !O_ALARM_RESET)
    else $error("alarm reset wider than one cycle");
  chk_trip_block:
    assert property (O_ALARM_RESET |-> !$past(I_TRIP_LOCKED))
    else $error("reset issued while trip locked");
  chk_coast_sync:
    assert property ($rose(O_CMD.coast) |-> !$past(I_TERM[4], 3))
    else $error("coast rose without synced low input");
  chk_run_cause:
    assert property ($rose(O_CMD.run) |-> $past(I_TERM[2], 3) || $past(I_TERM[3], 3))
    else $error("run rose without start input");
  chk_fault_hold:
    assert property (!I_TERM[4] [*5] |-> !$fell(O_CMD.ext_fault))
    else $error("fault cleared while interlock low");
  chk_fault_coast:
    assert property ($rose(O_CMD.ext_fault) |-> O_CMD.coast)
    else $error("fault raised without coasting");
endmodule

bind input_dispatch dispatch_chk u_chk (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_TERM(I_TERM), .I_TRIP_LOCKED(I_TRIP_LOCKED),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_CMD(O_CMD), .O_ALARM_RESET(O_ALARM_RESET));

// [verif/terminal_model.sv]
// Behavioural switches and controller driving the eight terminals
`timescale 1ns/100ps
module terminal_model (
  input  wire logic       i_clk,  // Control clock
  output logic      [7:0] o_term  // Terminal levels
);
  // Interlock idles high so the drive is not coasting
  initial o_term = 8'h10;

  // Sets one terminal at the next rising edge; raising start and reverse-and-start together is not prevented
  task automatic put(input int t, input logic v);
    @(posedge i_clk);
    o_term[t] <= v;
  endtask

  // Equal high and low widths of w cycles; callers also pass w below the minimum
  task automatic pulse(input int t, input int w);
    put(t, 1'b1);
    repeat (w) @(posedge i_clk);
    o_term[t] <= 1'b0;
    repeat (w) @(posedge i_clk);
  endtask
endmodule

// [verif/tb_drive_digital_input_dispatch.sv]
// Self-checking bench for the digital input dispatcher
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_drive_digital_input_dispatch;
  import dispatch_pkg::*;
  logic        clk = 0, rst_n = 0, trip = 0, off = 0, rd = 0, wr = 0;
  logic [7:0]  adr = 0, term;
  logic [31:0] wd = 0, rdata, ev;
  logic [15:0] ref_now = 0, frq_now = 0, r;
  logic        wq, irq, ares;
  cmd_s        cmd, e;
  int          error_cnt = 0, checks = 0, i, k, ares_n = 0;
  logic [31:0] q[$];

  always #25 clk = ~clk;
  terminal_model pm (.i_clk(clk), .o_term(term));
  input_dispatch #(.MIN_PULSE(8), .MS_CYC(4)) dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_TERM(term), .I_TRIP_LOCKED(trip), .I_OFF_KEY(off),
    .I_REF_NOW(ref_now), .I_FREQ_NOW(frq_now), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wq), .O_CMD(cmd), .O_ALARM_RESET(ares),
    .O_IRQ(irq));

  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Held until waitrequest is sampled low at a rising edge, released there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      stop_test();
    end
    wr <= 0;
    rd <= 0;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] v);
    q.push_back(v);
    bus(0, a, 0);
  endtask

  // Three-stage pin latency, so five edges is settled
  task automatic st(input int t, input logic v);
    pm.put(t, v);
    repeat (5) @(posedge clk);
  endtask

  // Read data taken at the edge that sees waitrequest low
  always @(posedge clk) begin
    if (ares === 1'b1) ares_n++;
    if (rd === 1'b1 && wq === 1'b0) begin
      ev = q.pop_front();
      `CHK(rdata, ev)
    end
  end

  initial begin
    void'($urandom(32'h3f34));
    ref_now = 16'($urandom) >> 1;
    frq_now = 16'($urandom) | 16'h1;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < NTERM; i++) rdx(OFS_SEL0 + 8'(4*i), 32'(SEL_RST[i*SEL_W +: SEL_W]));
    rdx(8'h40, 0);
    e = '0;
    // Terminals with no function raised alongside start
    for (i = 5; i < 8; i++) st(i, 1);
    st(2, 1);
    e.run = 1;
    rdx(OFS_STATE, 32'(e));
    `CHK(cmd, e)
    st(2, 0);
    e.run = 0;
    for (i = 5; i < 8; i++) st(i, 0);
    for (i = 0; i < 2; i++) begin
      bus(1, OFS_CTRL, 32'(i));
      st(3, 1);
      e.reverse = !i[0];
      rdx(OFS_STATE, 32'(e));
      st(3, 0);
    end
    e.reverse = 0;
    bus(1, OFS_CTRL, 0);
    bus(1, OFS_BRAKE, {16'd4, 16'($urandom) | 16'h1});
    bus(1, OFS_IMASK, 32'h3);
    for (i = 0; i < 4; i++) begin
      bus(1, OFS_SEL0 + 8'h10, 32'(i));
      bus(1, OFS_ISTAT, 32'hf);
      st(4, 0);
      e.coast = (i != 2);
      e.dc_brake = (i == 2);
      e.ext_fault = (i == 3);
      rdx(OFS_STATE, 32'(e));
      rdx(OFS_ISTAT, {30'h0, i == 1, i == 3});
      `CHK(irq, i == 1 || i == 3)
      if (i == 2) begin
        repeat (20) @(posedge clk);
        e.dc_brake = 0;
        rdx(OFS_STATE, 32'(e));
      end
      st(4, 1);
      e.coast = 0;
      rdx(OFS_STATE, 32'(e));
      @(posedge clk) off <= 1;
      @(posedge clk) off <= 0;
      e.ext_fault = 0;
      repeat (3) @(posedge clk);
      rdx(OFS_STATE, 32'(e));
    end
    bus(1, OFS_SEL0 + 8'h10, 32'h8);
    rdx(OFS_SEL0 + 8'h10, 32'h3);
    for (i = 0; i < 2; i++) begin
      @(posedge clk) trip <= i[0];
      bus(1, OFS_ISTAT, 32'hf);
      k = ares_n;
      pm.pulse(0, 6);
      rdx(OFS_ISTAT, {30'h0, !i[0], 1'b0});
      `CHK(ares_n - k, int'(!i[0]))
    end
    @(posedge clk) trip <= 0;
    bus(1, OFS_SEL0 + 8'h18, 32'h4);
    bus(1, OFS_SEL0 + 8'h1c, 32'h4);
    for (i = 0; i < 4; i++) begin
      pm.put(6, i[0]);
      st(7, i[1]);
      e.setup_sel = i[1:0];
      rdx(OFS_STATE, 32'(e));
    end
    st(6, 0);
    st(7, 0);
    e.setup_sel = 0;
    bus(1, OFS_SEL0 + 8'h18, 32'h7);
    r = ref_now;
    st(1, 1);
    e.freeze_ref = 1;
    rdx(OFS_STATE, 32'(e));
    // Later reference moves must not reach the frozen copy
    @(posedge clk) ref_now <= ~r;
    bus(1, OFS_ISTAT, 32'hf);
    pm.pulse(6, 10);
    pm.pulse(6, 3);
    bus(1, OFS_FREF, 0);
    rdx(OFS_FREF, 32'(r + STEP_SIZE));
    rdx(OFS_ISTAT, 32'h8);
    st(1, 0);
    rdx(OFS_FREF, 32'(r + STEP_SIZE));
    // Frozen output: start can no longer stop, DC hold still can
    e.freeze_ref = 0;
    st(3, 1);
    bus(1, OFS_SEL0 + 8'h0c, 32'h3);
    bus(1, OFS_SEL0 + 8'h14, 32'h3);
    bus(1, OFS_SEL0 + 8'h1c, 32'h7);
    st(2, 1);
    st(5, 1);
    pm.pulse(7, 9);
    st(2, 0);
    e.run = 1;
    e.freeze_out = 1;
    rdx(OFS_STATE, 32'(e));
    rdx(OFS_FFRQ, 32'(frq_now - STEP_SIZE));
    st(3, 0);
    e.run = 0;
    e.dc_brake = 1;
    rdx(OFS_STATE, 32'(e));
    stop_test();
  end
endmodule
